// >>> design/pmr_pkg.sv
package pmr_pkg;

	// register indices on the management access port
	localparam logic [4:0] IDX_CTRL = 5'h00;
	localparam logic [4:0] IDX_STAT = 5'h01;
	localparam logic [4:0] IDX_ID_HI = 5'h02;
	localparam logic [4:0] IDX_ID_LO = 5'h03;
	localparam logic [4:0] IDX_ADV = 5'h04;

	// basic control field positions
	localparam int CTL_RESET = 15;
	localparam int CTL_LOOP = 14;
	localparam int CTL_SPEED = 13;
	localparam int CTL_ANEN = 12;
	localparam int CTL_PDOWN = 11;
	localparam int CTL_RESTART = 9;
	localparam int CTL_DUPLEX = 8;
	localparam int CTL_COLTEST = 7;

	// basic status field positions
	localparam int STA_ANDONE = 5;
	localparam int STA_RFAULT = 4;
	localparam int STA_LINK = 2;
	localparam int STA_JABBER = 1;

	// advertisement field positions
	localparam int ADV_RFAULT = 13;
	localparam int ADV_PAUSE_LO = 10;
	localparam int ADV_100FD = 8;
	localparam int ADV_10FD = 6;
	localparam int ADV_10HD = 5;

	// reset values and writable masks
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] CTRL_WMASK = 16'h7980;
	localparam logic [15:0] ADV_RST = 16'h0081;
	localparam logic [15:0] ADV_WMASK = 16'h3DFF;
	localparam logic [15:0] STAT_CAP = 16'h7809;

	// pause encodings
	localparam logic [1:0] PAUSE_NONE = 2'h0;
	localparam logic [1:0] PAUSE_SYM = 2'h1;
	localparam logic [1:0] PAUSE_ASYM = 2'h2;
	localparam logic [1:0] PAUSE_BOTH = 2'h3;

	// software reset hold time
	localparam int CLK_PERIOD_NS = 100;
	localparam int SRST_TIME_NS = 500;
	localparam int SRST_CYCLES = (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] SRST_CNT_LOAD = 4'(SRST_CYCLES);

endpackage

// >>> design/pmr_latch_bit.sv
`timescale 1ns/1ps
// sticky event flag, cleared by a status read; a new event wins over the clear
module pmr_latch_bit (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic evt,
	input wire logic clr,
	output logic seen
);
	logic seen_ff;
	logic nxt_seen;

	assign nxt_seen = evt ? 1'b1 : (clr ? 1'b0 : seen_ff);
	assign seen = seen_ff;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			seen_ff <= 1'b0;
		end else begin
			seen_ff <= nxt_seen;
		end
	end
endmodule

// >>> design/pmr_regs.sv
// Functional notes
// - writing one to control bit 15 starts a soft reset; the bit self-clears.
// - control bit 14 selects loopback; zero means normal operation.
// - control bit 13 picks 100 or 10 Mbit/s, ignored under auto-negotiation.
// - control bit 12 enables auto-negotiation, overriding manual speed and duplex.
// - control bit 11 puts the PHY into general power-down.
// - after power-down ends, completed negotiation sets status bit 5.
// - writing one to control bit 9 restarts negotiation; the bit self-clears.
// - control bit 8 picks full or half duplex, ignored under auto-negotiation.
// - control bit 7 enables the collision signal test.
// - speed, negotiation enable and some advertised abilities reset from the strap.
// - basic status reports fixed capability bits.
// - status bit 5 reads one only once negotiation has completed.
// - status bit 4 latches high on a remote fault.
// - status bit 2 is a latching-low link indication.
// - status bit 1 latches high on a jabber condition.
// - identifier high returns sixteen identifier bits, read-only.
// - identifier low returns six identifier bits, model and revision.
// - advertised pause field and remote fault bit are read-write.
// - with both pause kinds advertised, at most one is configured.
// - advertisement holds read-write 100/10 full and half ability bits.
// - advertisement selector field resets to 00001.
// - registers are reached only by index through the access port.
`timescale 1ns/1ps
module pmr_regs #(
	parameter logic [15:0] OUI_HI = 16'h1234, // arbitrary value
	parameter logic [5:0] OUI_LO = 6'h2A, // arbitrary value
	parameter logic [5:0] MODEL_NUM = 6'h05, // arbitrary value
	parameter logic [3:0] REV_NUM = 4'h1 // arbitrary value
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [4:0] regIndex,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [15:0] regWrData,
	output logic [15:0] regRdData,
	output logic regRdValid,
	input wire logic speedStrap,
	input wire logic linkUp,
	input wire logic remoteFaultDet,
	input wire logic jabberDet,
	input wire logic anDone,
	input wire logic anSpeed100,
	input wire logic anFullDuplex,
	input wire logic [1:0] partnerPause,
	output logic loopbackEn,
	output logic speed100,
	output logic fullDuplex,
	output logic anEnable,
	output logic anRestart,
	output logic powerDown,
	output logic colTestEn,
	output logic phyResetBusy,
	output logic [1:0] pauseSel
);
	localparam int SRST_N = pmr_pkg::SRST_CYCLES;

	function automatic logic [15:0] ctrlDefault(input logic s);
		ctrlDefault = pmr_pkg::CTRL_RST;
		ctrlDefault[pmr_pkg::CTL_SPEED] = s;
		ctrlDefault[pmr_pkg::CTL_ANEN] = s;
	endfunction

	function automatic logic [15:0] advDefault(input logic s);
		advDefault = pmr_pkg::ADV_RST;
		advDefault[pmr_pkg::ADV_100FD] = s;
		advDefault[pmr_pkg::ADV_10FD] = s;
		advDefault[pmr_pkg::ADV_10HD] = s;
	endfunction

	// pick at most one pause kind from our advertisement and the partner's
	function automatic logic [1:0] resolvePause(input logic [1:0] ours, input logic [1:0] theirs);
		logic [1:0] common;
		common = ours & theirs;
		if (common == pmr_pkg::PAUSE_BOTH) begin
			resolvePause = pmr_pkg::PAUSE_SYM;
		end else begin
			resolvePause = common;
		end
	endfunction

	logic [15:0] ctrl_ff;
	logic [15:0] adv_ff;
	logic [3:0] srstCnt_ff;
	logic srstBusy_ff;
	logic restart_ff;
	logic strapDone_ff;
	logic strap_ff;
	logic anComplete_ff;
	logic speed100_ff;
	logic fullDuplex_ff;
	logic [1:0] pauseSel_ff;
	logic [15:0] regRdData_ff;
	logic regRdValid_ff;

	logic [15:0] nxt_ctrl;
	logic [15:0] nxt_adv;
	logic [3:0] nxt_srstCnt;
	logic nxt_srstBusy;
	logic nxt_restart;
	logic nxt_anComplete;
	logic nxt_speed100;
	logic nxt_fullDuplex;
	logic [1:0] nxt_pauseSel;
	logic [15:0] nxt_regRdData;

	logic ctrlWr;
	logic advWr;
	logic srstReq;
	logic loadDefaults;
	logic strapVal;
	logic statRead;
	logic rfSeen;
	logic jabSeen;
	logic linkDropSeen;
	logic rfRd;
	logic jabRd;
	logic linkRd;
	logic [15:0] ctrlWord;
	logic [15:0] statWord;
	logic [15:0] idLoWord;
	logic [15:0] rdWord;

	// access decode; writes during a soft reset are dropped
	assign ctrlWr = regWrEn && (regIndex == pmr_pkg::IDX_CTRL) && !srstBusy_ff;
	assign advWr = regWrEn && (regIndex == pmr_pkg::IDX_ADV) && !srstBusy_ff;
	assign statRead = regRdEn && (regIndex == pmr_pkg::IDX_STAT);
	assign srstReq = ctrlWr && regWrData[pmr_pkg::CTL_RESET];
	// other bits of a reset write are discarded, as the master is expected to zero them
	assign loadDefaults = !strapDone_ff || srstReq;
	assign strapVal = strapDone_ff ? strap_ff : speedStrap;

	assign nxt_ctrl = loadDefaults ? ctrlDefault(strapVal) :
		(ctrlWr ? (regWrData & pmr_pkg::CTRL_WMASK) : ctrl_ff);
	assign nxt_adv = loadDefaults ? advDefault(strapVal) :
		(advWr ? (regWrData & pmr_pkg::ADV_WMASK) : adv_ff);

	assign nxt_srstCnt = srstReq ? pmr_pkg::SRST_CNT_LOAD :
		((srstCnt_ff != 4'h0) ? srstCnt_ff - 4'h1 : 4'h0);
	assign nxt_srstBusy = (nxt_srstCnt != 4'h0);
	assign nxt_restart = ctrlWr && regWrData[pmr_pkg::CTL_RESTART] &&
		!regWrData[pmr_pkg::CTL_RESET];

	// completion only counts while negotiating, powered and out of reset
	assign nxt_anComplete = ctrl_ff[pmr_pkg::CTL_ANEN] && anDone && !srstBusy_ff &&
		!ctrl_ff[pmr_pkg::CTL_PDOWN] && !restart_ff;
	assign nxt_speed100 = ctrl_ff[pmr_pkg::CTL_ANEN] ? anSpeed100 :
		ctrl_ff[pmr_pkg::CTL_SPEED];
	assign nxt_fullDuplex = ctrl_ff[pmr_pkg::CTL_ANEN] ? anFullDuplex :
		ctrl_ff[pmr_pkg::CTL_DUPLEX];
	assign nxt_pauseSel = anComplete_ff ?
		resolvePause(adv_ff[pmr_pkg::ADV_PAUSE_LO +: 2], partnerPause) :
		pmr_pkg::PAUSE_NONE;

	// latched status: the read shows what was latched, then the latch clears
	pmr_latch_bit uRfLatch (
		.mclk(mclk),
		.resetn(resetn),
		.evt(remoteFaultDet),
		.clr(statRead),
		.seen(rfSeen)
	);
	pmr_latch_bit uJabLatch (
		.mclk(mclk),
		.resetn(resetn),
		.evt(jabberDet),
		.clr(statRead),
		.seen(jabSeen)
	);
	pmr_latch_bit uLinkLatch (
		.mclk(mclk),
		.resetn(resetn),
		.evt(!linkUp),
		.clr(statRead),
		.seen(linkDropSeen)
	);
	assign rfRd = rfSeen || remoteFaultDet;
	assign jabRd = jabSeen || jabberDet;
	assign linkRd = linkUp && !linkDropSeen;

	assign ctrlWord = ctrl_ff | {srstBusy_ff, 5'h00, restart_ff, 9'h000};
	assign statWord = pmr_pkg::STAT_CAP |
		{10'h000, anComplete_ff, rfRd, 1'b0, linkRd, jabRd, 1'b0};
	assign idLoWord = {OUI_LO, MODEL_NUM, REV_NUM};
	assign rdWord = (regIndex == pmr_pkg::IDX_CTRL) ? ctrlWord :
		(regIndex == pmr_pkg::IDX_STAT) ? statWord :
		(regIndex == pmr_pkg::IDX_ID_HI) ? OUI_HI :
		(regIndex == pmr_pkg::IDX_ID_LO) ? idLoWord :
		(regIndex == pmr_pkg::IDX_ADV) ? adv_ff : 16'h0000;
	assign nxt_regRdData = regRdEn ? rdWord : regRdData_ff;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			strapDone_ff <= 1'b0;
			strap_ff <= 1'b0;
		end else begin
			strapDone_ff <= 1'b1;
			if (!strapDone_ff) begin
				strap_ff <= speedStrap;
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ctrl_ff <= pmr_pkg::CTRL_RST;
			adv_ff <= pmr_pkg::ADV_RST;
			srstCnt_ff <= 4'h0;
			srstBusy_ff <= 1'b0;
			restart_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			adv_ff <= nxt_adv;
			srstCnt_ff <= nxt_srstCnt;
			srstBusy_ff <= nxt_srstBusy;
			restart_ff <= nxt_restart;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			anComplete_ff <= 1'b0;
			speed100_ff <= 1'b0;
			fullDuplex_ff <= 1'b0;
			pauseSel_ff <= pmr_pkg::PAUSE_NONE;
		end else begin
			anComplete_ff <= nxt_anComplete;
			speed100_ff <= nxt_speed100;
			fullDuplex_ff <= nxt_fullDuplex;
			pauseSel_ff <= nxt_pauseSel;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			regRdData_ff <= 16'h0000;
			regRdValid_ff <= 1'b0;
		end else begin
			regRdData_ff <= nxt_regRdData;
			regRdValid_ff <= regRdEn;
		end
	end

	assign regRdData = regRdData_ff;
	assign regRdValid = regRdValid_ff;
	assign loopbackEn = ctrl_ff[pmr_pkg::CTL_LOOP];
	assign anEnable = ctrl_ff[pmr_pkg::CTL_ANEN];
	assign powerDown = ctrl_ff[pmr_pkg::CTL_PDOWN];
	assign colTestEn = ctrl_ff[pmr_pkg::CTL_COLTEST];
	assign speed100 = speed100_ff;
	assign fullDuplex = fullDuplex_ff;
	assign anRestart = restart_ff;
	assign phyResetBusy = srstBusy_ff;
	assign pauseSel = pauseSel_ff;

	default clocking cbMain @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	sequence seqCtrlWrite;
		regWrEn && (regIndex == pmr_pkg::IDX_CTRL) && !phyResetBusy;
	endsequence

	sequence seqStatRead;
		regRdEn && (regIndex == pmr_pkg::IDX_STAT);
	endsequence

	AST_SRST_START: assert property (
		seqCtrlWrite and regWrData[15] |=> phyResetBusy && regRdValid == $past(regRdEn)
	) else $error("soft reset did not start");

	AST_SRST_END: assert property (
		$rose(phyResetBusy) |-> ##[1:SRST_N] !phyResetBusy
	) else $error("soft reset bit did not self-clear");

	AST_SRST_DEFAULTS: assert property (
		$rose(phyResetBusy) |-> !loopbackEn && !powerDown && !colTestEn
	) else $error("soft reset left control bits set");

	AST_LOOPBACK: assert property (
		seqCtrlWrite and !regWrData[15] |=> loopbackEn == $past(regWrData[14])
	) else $error("loopback bit not applied");

	AST_SPEED_AUTO: assert property (
		anEnable |=> speed100 == $past(anSpeed100)
	) else $error("manual speed used under auto-negotiation");

	AST_SPEED_MANUAL: assert property (
		seqCtrlWrite and !regWrData[15] and !regWrData[12] |=> ##1
		speed100 == $past(regWrData[13], 2)
	) else $error("manual speed not applied");

	AST_DUPLEX_MANUAL: assert property (
		seqCtrlWrite and !regWrData[15] and !regWrData[12] |=> ##1
		fullDuplex == $past(regWrData[8], 2)
	) else $error("manual duplex not applied");

	AST_PDOWN_NO_DONE: assert property (
		powerDown |=> !statWord[5]
	) else $error("completion reported in power-down");

	AST_DONE_BIT: assert property (
		anEnable && anDone && !powerDown && !phyResetBusy && !anRestart |=> statWord[5]
	) else $error("completion not reported");

	AST_RESTART_PULSE: assert property (
		seqCtrlWrite and regWrData[9] and !regWrData[15] |=> anRestart ##1 !anRestart
	) else $error("restart bit did not self-clear");

	AST_JABBER_HOLD: assert property (
		jabberDet ##1 (!statRead) [*3] ##1 seqStatRead |=> regRdData[1]
	) else $error("jabber event lost before read");

	AST_RFAULT_HOLD: assert property (
		remoteFaultDet ##1 (!statRead) [*3] ##1 seqStatRead |=> regRdData[4]
	) else $error("remote fault event lost before read");

	AST_LINK_LOW: assert property (
		!linkUp ##1 (!statRead) [*3] ##1 seqStatRead |=> !regRdData[2]
	) else $error("link drop lost before read");

	AST_LINK_RECOVER: assert property (
		(seqStatRead and linkUp) ##1 linkUp [*4] ##0 seqStatRead |=> regRdData[2]
	) else $error("link bit did not follow live state after read");

	AST_PAUSE_ONE: assert property (
		pauseSel != pmr_pkg::PAUSE_BOTH
	) else $error("both pause kinds configured");

	AST_ID_HIGH: assert property (
		regRdEn && (regIndex == pmr_pkg::IDX_ID_HI) |=> regRdData == OUI_HI && regRdValid
	) else $error("identifier high wrong");

	AST_CAPS: assert property (
		seqStatRead |=> (regRdData & 16'hF809) == pmr_pkg::STAT_CAP
	) else $error("capability bits wrong");

	AST_RSVD_CTRL: assert property (
		regRdEn && (regIndex == pmr_pkg::IDX_CTRL) |=> regRdData[6:0] == 7'h00 && !regRdData[10]
	) else $error("reserved control bits not zero");

	AST_STRAP: assert property (
		$rose(strapDone_ff) |-> anEnable == $past(speedStrap) && speed100 == 1'b0
	) else $error("strap default not loaded");

endmodule

// >>> verification/pmr_line_model.sv
`timescale 1ns/1ps
// line-side peer: negotiation ends AN_CYC cycles after it may start, partner offers both pauses
module pmr_line_model #(
	parameter int AN_CYC = 20
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic anEnable,
	input wire logic powerDown,
	input wire logic anRestart,
	output logic anDone,
	output logic anSpeed100,
	output logic anFullDuplex,
	output logic [1:0] partnerPause
);
	int cnt;
	assign anSpeed100 = 1'b1;
	assign anFullDuplex = 1'b1;
	assign partnerPause = 2'h3;
	assign anDone = (cnt >= AN_CYC);
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cnt <= 0;
		end else if (!anEnable || powerDown || anRestart) begin
			cnt <= 0;
		end else if (cnt < AN_CYC) begin
			cnt <= cnt + 1;
		end
	end
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic [4:0] regIndex = 5'h00;
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	logic [15:0] regWrData = 16'h0000;
	logic speedStrap = 1'b1;
	logic linkUp = 1'b1;
	logic remoteFaultDet = 1'b0;
	logic jabberDet = 1'b0;
	logic [15:0] regRdData;
	logic regRdValid, loopbackEn, speed100, fullDuplex, anEnable, anRestart;
	logic powerDown, colTestEn, phyResetBusy, anDone, anSpeed100, anFullDuplex;
	logic [1:0] partnerPause, pauseSel;
	int n_fail = 0;
	int n_tests = 0;
	int n;
	wire [15:0] outs = {10'h000, loopbackEn, speed100, fullDuplex, colTestEn, anEnable, powerDown};

	initial begin
		forever #50 mclk = ~mclk;
	end

	pmr_regs dut (.mclk(mclk), .resetn(resetn), .regIndex(regIndex), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
		.regRdValid(regRdValid), .speedStrap(speedStrap), .linkUp(linkUp),
		.remoteFaultDet(remoteFaultDet), .jabberDet(jabberDet), .anDone(anDone),
		.anSpeed100(anSpeed100), .anFullDuplex(anFullDuplex), .partnerPause(partnerPause),
		.loopbackEn(loopbackEn), .speed100(speed100), .fullDuplex(fullDuplex),
		.anEnable(anEnable), .anRestart(anRestart), .powerDown(powerDown),
		.colTestEn(colTestEn), .phyResetBusy(phyResetBusy), .pauseSel(pauseSel));

	pmr_line_model #(.AN_CYC(20)) peer (.mclk(mclk), .resetn(resetn), .anEnable(anEnable),
		.powerDown(powerDown), .anRestart(anRestart), .anDone(anDone),
		.anSpeed100(anSpeed100), .anFullDuplex(anFullDuplex), .partnerPause(partnerPause));

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one indexed write, strobe held for exactly one taken edge
	task automatic wr(input logic [4:0] idx, input logic [15:0] d);
		@(posedge mclk);
		regWrEn <= 1'b1;
		regIndex <= idx;
		regWrData <= d;
		@(posedge mclk);
		regWrEn <= 1'b0;
		#1;
	endtask

	task automatic rdc(input string what, input logic [4:0] idx, input logic [15:0] exp);
		@(posedge mclk);
		regRdEn <= 1'b1;
		regIndex <= idx;
		@(posedge mclk);
		regRdEn <= 1'b0;
		#1;
		chk({what, " valid"}, 16'h0001, {15'h0000, regRdValid});
		chk(what, exp, regRdData);
	endtask

	task automatic settle();
		repeat (2) @(posedge mclk);
		#1;
	endtask

	initial begin
		repeat (10) @(posedge mclk);
		resetn <= 1'b1;
		repeat (2) @(posedge mclk);
		wr(pmr_pkg::IDX_ID_HI, 16'hFFFF);
		wr(pmr_pkg::IDX_ID_LO, 16'h0000);
		rdc("ctrl", pmr_pkg::IDX_CTRL, 16'h3000);
		rdc("adv", pmr_pkg::IDX_ADV, 16'h01E1);
		rdc("idhi", pmr_pkg::IDX_ID_HI, 16'h1234);
		rdc("idlo", pmr_pkg::IDX_ID_LO, 16'hA851);
		rdc("unmapped", 5'h05, 16'h0000);
		$display("test defaults done");
		repeat (30) @(posedge mclk);
		remoteFaultDet <= 1'b1;
		jabberDet <= 1'b1;
		linkUp <= 1'b0;
		repeat (2) @(posedge mclk);
		remoteFaultDet <= 1'b0;
		jabberDet <= 1'b0;
		linkUp <= 1'b1;
		repeat (2) @(posedge mclk);
		rdc("stat held", pmr_pkg::IDX_STAT, 16'h783B);
		wr(pmr_pkg::IDX_STAT, 16'hFFFF);
		rdc("stat live", pmr_pkg::IDX_STAT, 16'h782D);
		$display("test status done");
		wr(pmr_pkg::IDX_ADV, 16'hFFFF);
		rdc("adv rw", pmr_pkg::IDX_ADV, 16'h3DFF);
		for (int p = 0; p < 4; p++) begin
			wr(pmr_pkg::IDX_ADV, {4'h0, 2'(p), 10'h001});
			settle();
			chk("pause", (p == 3) ? 16'h0001 : 16'(p), {14'h0000, pauseSel});
		end
		$display("test pause done");
		wr(pmr_pkg::IDX_CTRL, 16'h6180);
		settle();
		chk("manual on", 16'h003C, outs);
		wr(pmr_pkg::IDX_CTRL, 16'h047F);
		settle();
		chk("manual off", 16'h0000, outs);
		rdc("ctrl rsvd", pmr_pkg::IDX_CTRL, 16'h0000);
		wr(pmr_pkg::IDX_CTRL, 16'h1000);
		settle();
		chk("an override", 16'h001A, outs);
		wr(pmr_pkg::IDX_CTRL, 16'h1800);
		chk("pdown", 16'h0001, {15'h0000, powerDown});
		repeat (30) @(posedge mclk);
		rdc("stat pd", pmr_pkg::IDX_STAT, 16'h780D);
		wr(pmr_pkg::IDX_CTRL, 16'h1000);
		rdc("stat early", pmr_pkg::IDX_STAT, 16'h780D);
		repeat (30) @(posedge mclk);
		rdc("stat done", pmr_pkg::IDX_STAT, 16'h782D);
		wr(pmr_pkg::IDX_CTRL, 16'h1200);
		chk("restart", 16'h0001, {15'h0000, anRestart});
		@(posedge mclk);
		#1;
		chk("restart end", 16'h0000, {15'h0000, anRestart});
		rdc("ctrl sc", pmr_pkg::IDX_CTRL, 16'h1000);
		rdc("stat rst", pmr_pkg::IDX_STAT, 16'h780D);
		$display("test control done");
		wr(pmr_pkg::IDX_CTRL, 16'h8000);
		chk("busy", 16'h0001, {15'h0000, phyResetBusy});
		wr(pmr_pkg::IDX_CTRL, 16'h4000);
		n = 0;
		while (phyResetBusy === 1'b1 && n < 20) begin
			@(posedge mclk);
			#1;
			n++;
		end
		// a stuck busy flag counts as a mismatch; the run still ends at the verdict
		if (n >= 20) begin
			n_fail++;
		end
		chk("busy len", 16'(pmr_pkg::SRST_CYCLES - 2), 16'(n));
		chk("refused", 16'h0000, {15'h0000, loopbackEn});
		rdc("ctrl srst", pmr_pkg::IDX_CTRL, 16'h3000);
		rdc("adv srst", pmr_pkg::IDX_ADV, 16'h01E1);
		$display("test soft reset done");
		@(posedge mclk);
		resetn <= 1'b0;
		speedStrap <= 1'b0;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		repeat (2) @(posedge mclk);
		rdc("ctrl strap0", pmr_pkg::IDX_CTRL, 16'h0000);
		rdc("adv strap0", pmr_pkg::IDX_ADV, 16'h0081);
		$display("test strap done");
		give_verdict();
	end
endmodule
